//--- common/lcd_ctrl_map.vh
// Register offsets, field positions and reset values of the LCD control block.
// Assumes inclusion by bare name from logic/ sources; definitions only.
`ifndef LCD_CTRL_MAP_VH
`define LCD_CTRL_MAP_VH

// Register offsets (byte bus, 8-bit registers)
`define OFS_MAIN_CTRL     8'h00
`define OFS_FRAME_PS      8'h01
`define OFS_LADDER_REF    8'h02
`define OFS_CONTRAST      8'h03
`define OFS_LADDER_SW     8'h04
`define OFS_STATUS        8'h05
`define OFS_SEG_EN_BASE   8'h08
`define OFS_PIXEL_BASE    8'h10

// Bank counts
`define SEG_EN_BANKS      3
`define PIXEL_BANKS       12

// Main control fields
`define MAIN_EN_BIT       7
`define MAIN_SLPEN_BIT    6
`define MAIN_CS_LSB       2
`define MAIN_CS_W         2
`define MAIN_MUX_LSB      0
`define MAIN_RESET        8'h00

// Frame prescale fields
`define PS_HALF_BIAS_BIT  6
`define PS_LP_LSB         0
`define PS_LP_W           4
`define PS_RESET          8'h00

// Ladder reference bit
`define REF_EN_BIT        7
`define REF_RESET         8'h00

// Contrast field
`define CST_W             3
`define CST_RESET         8'h00

// Ladder switching fields
`define SW_A_LSB          6
`define SW_B_LSB          4
`define SW_LAT_LSB        0
`define SW_LAT_W          3
`define SW_RESET          8'h00

// Clock source codes
`define CS_SYS_DIV        2'h0
`define CS_SEC_OSC        2'h1
`define CS_LF_OSC         2'h2

// Timing counts
`define SYS_DIV_COUNT     8'hFF
`define BASE_DIV_COUNT    5'h1F

`endif

//--- logic/lcd_pixel_mem.v
// Pixel data memory: twelve 8-bit banks, registered read port.
// Assumes one clock; contents survive every reset of the block.
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_mem (
  input  wire       ref_clk_in,
  input  wire       wr_en_in,
  input  wire [3:0] wr_idx_in,
  input  wire [7:0] wr_data_in,
  input  wire [3:0] rd_idx_in,
  output reg  [7:0] rd_data_ff_out
);
  reg [7:0] mem_ff [0:11];

  // No reset here on purpose: pixels keep value through soft resets
  always @(posedge ref_clk_in) begin
    if (wr_en_in && (wr_idx_in < 4'hC)) begin
      mem_ff[wr_idx_in] <= wr_data_in;
    end
    if (rd_idx_in < 4'hC) begin
      rd_data_ff_out <= mem_ff[rd_idx_in];
    end else begin
      rd_data_ff_out <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- logic/lcd_clock_bias_segment_ctrl.v
// LCD clock source selection, frame prescaler, bias ladder and segment control.
// Assumes a synchronous byte register port and oscillator ticks synchronous
// to ref_clk_in; the analog ladder and glass sit outside.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_map.vh"

// Notes on behaviour
// R1: contrast code sets ladder resistance k/7
// R2: contrast upper five bits read zero
// R3: segment enable gives pin to LCD
// R4: pixel bit set means dark pixel
// R5: pixel data untouched by block reset
// R6: three LCD clock sources by select
// R7: system divide fixed at 256
// R8: software enables crystal before selecting it
// R9: oscillator sources keep running in sleep
// R10: hidden 4-bit prescaler, ratio 1 to 16
// R11: static, half and third bias types
// R12: half bias shorts middle ladder resistor
// R13: ladder power off, low, medium, high
// R14: ladder forced off when inactive
// R15: mode A after transition, then B
// R16: 3-bit interval, zero skips mode A
// R17: 5-bit base prescaler times A/B select
// R18: interval restarts each transition, holds B
module lcd_clock_bias_segment_ctrl (
  input  wire        ref_clk_in,
  input  wire        sys_rst_in,
  input  wire [7:0]  addr_in,
  input  wire [7:0]  wr_data_in,
  input  wire        wr_stb_in,
  input  wire        rd_stb_in,
  output reg  [7:0]  rd_data_ff_out,
  input  wire        sec_osc_tick_in,
  input  wire        lf_osc_tick_in,
  input  wire        sleep_in,
  output reg         frame_tick_ff_out,
  output reg         lcd_active_ff_out,
  output reg  [1:0]  ladder_power_ff_out,
  output reg         half_bias_short_ff_out,
  output reg  [2:0]  contrast_select_ff_out,
  output reg  [1:0]  bias_type_ff_out,
  output reg  [23:0] segment_pin_enable_ff_out,
  output reg  [1:0]  mux_select_ff_out
);
  reg [7:0]  main_ctrl_ff;
  reg [7:0]  frame_ps_ff;
  reg [7:0]  ladder_ref_ff;
  reg [7:0]  ladder_sw_ff;
  reg [2:0]  contrast_ff;
  reg [23:0] seg_en_ff;
  reg [7:0]  sys_div_ff;
  reg [4:0]  base_div_ff;
  reg [3:0]  frame_cnt_ff;
  reg [2:0]  a_cnt_ff;
  reg        in_a_ff;
  reg        rd_pix_ff;
  reg [7:0]  rd_reg_ff;
  wire [7:0] pix_rd_data;

  wire [1:0] clk_src = main_ctrl_ff[`MAIN_CS_LSB +: `MAIN_CS_W];
  wire [3:0] lp_sel  = frame_ps_ff[`PS_LP_LSB +: `PS_LP_W];
  wire [2:0] lat_sel = ladder_sw_ff[`SW_LAT_LSB +: `SW_LAT_W];

  // Register index decode for banked registers
  function [3:0] bank_index;
    input [7:0] addr;
    input [7:0] base;
    begin
      bank_index = addr[3:0] - base[3:0];
    end
  endfunction

  wire pix_hit = (addr_in >= `OFS_PIXEL_BASE) &&
                 (addr_in < (`OFS_PIXEL_BASE + 8'h0C));
  wire seg_hit = (addr_in >= `OFS_SEG_EN_BASE) &&
                 (addr_in < (`OFS_SEG_EN_BASE + 8'h03));
  wire [3:0] pix_idx = bank_index(addr_in, `OFS_PIXEL_BASE);
  wire [3:0] seg_idx = bank_index(addr_in, `OFS_SEG_EN_BASE);

  // Pixel memory kept outside the reset domain
  lcd_pixel_mem u_pix (
    .ref_clk_in     (ref_clk_in),
    .wr_en_in       (wr_stb_in && pix_hit), // R4 R5
    .wr_idx_in      (pix_idx),
    .wr_data_in     (wr_data_in),
    .rd_idx_in      (pix_hit ? pix_idx : 4'hF),
    .rd_data_ff_out (pix_rd_data)
  );

  // Register writes
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      main_ctrl_ff  <= `MAIN_RESET;
      frame_ps_ff   <= `PS_RESET;
      ladder_ref_ff <= `REF_RESET;
      ladder_sw_ff  <= `SW_RESET;
      contrast_ff   <= 3'h0;
      seg_en_ff     <= 24'h000000; // R3
    end else if (wr_stb_in) begin
      case (addr_in)
        `OFS_MAIN_CTRL:  main_ctrl_ff  <= wr_data_in;
        `OFS_FRAME_PS:   frame_ps_ff   <= wr_data_in;
        `OFS_LADDER_REF: ladder_ref_ff <= wr_data_in;
        `OFS_LADDER_SW:  ladder_sw_ff  <= {wr_data_in[7:4], 1'b0, wr_data_in[2:0]};
        `OFS_CONTRAST:   contrast_ff   <= wr_data_in[2:0]; // R1
        default: begin
          if (seg_hit) begin
            seg_en_ff[seg_idx*8 +: 8] <= wr_data_in; // R3
          end
        end
      endcase
    end
  end

  // Read path; answer one cycle later, unmapped reads give zero
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_reg_ff <= 8'h00;
      rd_pix_ff <= 1'b0;
    end else begin
      rd_pix_ff <= rd_stb_in && pix_hit;
      if (rd_stb_in) begin
        case (addr_in)
          `OFS_MAIN_CTRL:  rd_reg_ff <= main_ctrl_ff;
          `OFS_FRAME_PS:   rd_reg_ff <= frame_ps_ff; // R10
          `OFS_LADDER_REF: rd_reg_ff <= ladder_ref_ff;
          `OFS_LADDER_SW:  rd_reg_ff <= ladder_sw_ff;
          `OFS_CONTRAST:   rd_reg_ff <= {5'h00, contrast_ff}; // R2
          `OFS_STATUS:     rd_reg_ff <= {lcd_active_ff_out, in_a_ff, 6'h00};
          default: begin
            if (seg_hit) begin
              rd_reg_ff <= seg_en_ff[seg_idx*8 +: 8];
            end else begin
              rd_reg_ff <= 8'h00;
            end
          end
        endcase
      end else begin
        rd_reg_ff <= 8'h00;
      end
    end
  end

  // Merge memory data; the memory read register is already one cycle late
  always @* begin
    rd_data_ff_out = rd_pix_ff ? pix_rd_data : rd_reg_ff;
  end

  // Active flag: enabled, and sleep only allowed on oscillator sources
  wire src_runs = !sleep_in || (clk_src != `CS_SYS_DIV); // R9
  wire active_nxt = main_ctrl_ff[`MAIN_EN_BIT] && src_runs &&
                    (clk_src != 2'h3);

  // Fixed divide-by-256 of the system clock
  always @(posedge ref_clk_in) begin
    if (sys_rst_in || sleep_in) begin
      sys_div_ff <= 8'h00;
    end else begin
      sys_div_ff <= sys_div_ff + 8'h01; // R7
    end
  end

  // Source select: one-cycle tick from the chosen clock
  reg src_tick;
  always @* begin
    case (clk_src)
      `CS_SYS_DIV: src_tick = (sys_div_ff == `SYS_DIV_COUNT) && !sleep_in; // R6 R7
      `CS_SEC_OSC: src_tick = sec_osc_tick_in; // R6 R8
      `CS_LF_OSC:  src_tick = lf_osc_tick_in;  // R6
      default:     src_tick = 1'b0;
    endcase
  end

  // Base divider: 32 ticks per base period; also paces mode A
  wire base_tick = src_tick && (base_div_ff == `BASE_DIV_COUNT); // R17
  wire a_step    = src_tick && (base_div_ff[1:0] == 2'h3); // R17

  // Frame prescaler, not visible to software
  wire frame_nxt = base_tick && (frame_cnt_ff == lp_sel); // R10

  always @(posedge ref_clk_in) begin
    if (sys_rst_in || !active_nxt) begin
      base_div_ff  <= 5'h00;
      frame_cnt_ff <= 4'h0;
    end else if (src_tick) begin
      base_div_ff <= base_div_ff + 5'h01;
      if (base_tick) begin
        frame_cnt_ff <= (frame_cnt_ff == lp_sel) ? 4'h0 : frame_cnt_ff + 4'h1; // R10
      end
    end
  end

  // Mode A window: restart on each transition, hold B at terminal count
  always @(posedge ref_clk_in) begin
    if (sys_rst_in || !active_nxt) begin
      in_a_ff  <= 1'b0;
      a_cnt_ff <= 3'h0;
    end else if (frame_nxt) begin
      in_a_ff  <= (lat_sel != 3'h0); // R15 R16 R18
      a_cnt_ff <= lat_sel;           // R18
    end else if (in_a_ff && a_step) begin
      a_cnt_ff <= a_cnt_ff - 3'h1;
      if (a_cnt_ff == 3'h1) begin
        in_a_ff <= 1'b0; // R15 R18
      end
    end
  end

  // Outputs toward ladder and pads
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      frame_tick_ff_out         <= 1'b0;
      lcd_active_ff_out         <= 1'b0;
      ladder_power_ff_out       <= 2'h0;
      half_bias_short_ff_out    <= 1'b0;
      contrast_select_ff_out    <= 3'h0;
      bias_type_ff_out          <= 2'h0;
      segment_pin_enable_ff_out <= 24'h000000;
      mux_select_ff_out         <= 2'h0;
    end else begin
      frame_tick_ff_out   <= frame_nxt && active_nxt;
      lcd_active_ff_out   <= active_nxt;
      // Ladder off when inactive or reference disabled
      if (!active_nxt || !ladder_ref_ff[`REF_EN_BIT]) begin
        ladder_power_ff_out <= 2'h0; // R13 R14
      end else if (in_a_ff) begin
        ladder_power_ff_out <= ladder_sw_ff[`SW_A_LSB +: 2]; // R13 R15
      end else begin
        ladder_power_ff_out <= ladder_sw_ff[`SW_B_LSB +: 2]; // R13 R15
      end
      half_bias_short_ff_out    <= frame_ps_ff[`PS_HALF_BIAS_BIT]; // R12
      // 0 static, 1 half, 2 third
      bias_type_ff_out          <= (main_ctrl_ff[1:0] == 2'h0) ? 2'h0 :
                                   (frame_ps_ff[`PS_HALF_BIAS_BIT] ? 2'h1 : 2'h2); // R11
      contrast_select_ff_out    <= contrast_ff; // R1
      segment_pin_enable_ff_out <= seg_en_ff;   // R3
      mux_select_ff_out         <= main_ctrl_ff[`MAIN_MUX_LSB +: 2];
    end
  end
endmodule
`default_nettype wire

//--- sim/lcd_ctrl_monitor.sv
// Port checker for the LCD control block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_map.vh"
module lcd_ctrl_monitor (
  input wire       ref_clk_in,
  input wire       sys_rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire       wr_stb_in,
  input wire       rd_stb_in,
  input wire [7:0] rd_data_ff_out,
  input wire       frame_tick_ff_out,
  input wire       lcd_active_ff_out,
  input wire [1:0] ladder_power_ff_out,
  input wire [2:0] contrast_select_ff_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Contrast register traffic
  wire cst_wr = wr_stb_in && addr_in == `OFS_CONTRAST;
  wire cst_rd = rd_stb_in && addr_in == `OFS_CONTRAST;
  AST_RD_IDLE: assert property (!$past(rd_stb_in) |-> rd_data_ff_out == 8'h00)
    else $error("read data without a strobe");
  AST_CST_UPPER: assert property ($past(cst_rd) |-> rd_data_ff_out[7:3] == 5'h00)
    else $error("contrast upper bits not zero");
  AST_CST_READ: assert property ($past(cst_rd) |-> rd_data_ff_out[2:0] == contrast_select_ff_out)
    else $error("contrast read differs from output");
  // Output pin trails the register by one cycle, so a write shows two edges on
  AST_CST_WRITE: assert property (cst_wr |=> ##1
    contrast_select_ff_out == $past(wr_data_in[2:0], 2))
    else $error("contrast write not applied");
  // Reset edge and the cycle after a write may move the pin legally
  AST_CST_HOLD: assert property (!cst_wr && !$past(cst_wr) && !sys_rst_in |=>
    $stable(contrast_select_ff_out))
    else $error("contrast changed without a write");
  // Inactive block: no frames, ladder off; a level lag of one cycle is allowed
  AST_OFF_INACTIVE: assert property (!lcd_active_ff_out [*2] |-> ladder_power_ff_out == 2'h0)
    else $error("ladder powered while inactive");
  AST_NO_TICK_IDLE: assert property (!lcd_active_ff_out [*2] |-> !frame_tick_ff_out)
    else $error("frame tick while inactive");
  AST_TICK_PULSE: assert property (frame_tick_ff_out |=> !frame_tick_ff_out)
    else $error("frame tick longer than one cycle");
endmodule
bind lcd_clock_bias_segment_ctrl lcd_ctrl_monitor i_mon (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .addr_in(addr_in),
  .wr_data_in(wr_data_in),
  .wr_stb_in(wr_stb_in),
  .rd_stb_in(rd_stb_in),
  .rd_data_ff_out(rd_data_ff_out),
  .frame_tick_ff_out(frame_tick_ff_out),
  .lcd_active_ff_out(lcd_active_ff_out),
  .ladder_power_ff_out(ladder_power_ff_out),
  .contrast_select_ff_out(contrast_select_ff_out)
);
`default_nettype wire

//--- sim/lcd_glass_model.sv
// Passive segment glass: counts powered common/segment transitions.
// Assumes frame ticks and ladder level from the control block.
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model (
  input  wire         ref_clk_in,
  input  wire         frame_tick_in,
  input  wire [1:0]   ladder_power_in,
  output logic [15:0] frames_out
);
  initial frames_out = 16'h0000;
  // Only a powered ladder charges the pixel capacitance
  always @(posedge ref_clk_in) begin
    if (frame_tick_in && ladder_power_in != 2'h0) begin
      frames_out <= frames_out + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench: registers, clock sources, prescaler, ladder modes.
// Assumes the block, its map header and the glass model; ticks made here.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_map.vh"
module tb;
  // Low-frequency ticks come from the bench so a stalled source can be shown
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, slp = 1'b0, sec = 1'b0, lf = 1'b1;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, v;
  logic        tick, act, hbs;
  logic [1:0]  pwr, bias, mux;
  logic [2:0]  cst;
  logic [23:0] seg;
  logic [15:0] frames;
  logic [31:0] seed = 32'h49B0;
  int          miscompares = 0, checks_done = 0, cyc = 0, n;
  initial forever #2.5 clk = ~clk;
  // Crystal ticks every other cycle, running before it is selected
  always @(posedge clk) sec <= ~sec;
  lcd_clock_bias_segment_ctrl i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr),
    .wr_data_in(wd), .wr_stb_in(wr), .rd_stb_in(rd), .rd_data_ff_out(rdat),
    .sec_osc_tick_in(sec), .lf_osc_tick_in(lf), .sleep_in(slp),
    .frame_tick_ff_out(tick), .lcd_active_ff_out(act), .ladder_power_ff_out(pwr),
    .half_bias_short_ff_out(hbs), .contrast_select_ff_out(cst), .bias_type_ff_out(bias),
    .segment_pin_enable_ff_out(seg), .mux_select_ff_out(mux));
  lcd_glass_model i_glass (.ref_clk_in(clk), .frame_tick_in(tick), .ladder_power_in(pwr),
    .frames_out(frames));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdat);
  endtask
  // Cycles between two frame ticks; a hang is cut by the cycle ceiling
  task automatic period;
    @(negedge clk);
    while (tick !== 1'b1) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1);
  endtask
  task automatic ladder(input logic [1:0] e3, input logic [1:0] e14);
    period();
    repeat (3) @(negedge clk);
    chk("ladder early", e3, pwr);
    repeat (11) @(negedge clk);
    chk("ladder late", e14, pwr);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("contrast reset", `OFS_CONTRAST, 8'h00);
    rchk("seg bank reset", `OFS_SEG_EN_BASE, 8'h00);
    rchk("unmapped", 8'h1F, 8'h00);
    // Contrast extremes first, then random codes and segment banks
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = (i < 2) ? (i == 0 ? 8'hF8 : 8'hFF) : seed[7:0];
      wreg(`OFS_CONTRAST, v);
      rchk("contrast read", `OFS_CONTRAST, {5'h00, v[2:0]});
      chk("contrast out", v[2:0], cst);
      wreg(`OFS_SEG_EN_BASE + 8'(i % 3), seed[15:8]);
      repeat (2) @(negedge clk);
      chk("seg pins", seed[15:8], seg[8 * (i % 3) +: 8]);
    end
    wreg(`OFS_PIXEL_BASE, seed[23:16]);
    wreg(`OFS_PIXEL_BASE + 8'h0B, seed[31:24]);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rchk("pixel first", `OFS_PIXEL_BASE, seed[23:16]);
    rchk("pixel last", `OFS_PIXEL_BASE + 8'h0B, seed[31:24]);
    chk("seg after reset", 24'h000000, seg);
    $display("test registers done");
    // Low-frequency source, third-bias mux, A high then B low
    wreg(`OFS_LADDER_REF, 8'h80);
    wreg(`OFS_LADDER_SW, 8'hDA);
    rchk("ladder sw", `OFS_LADDER_SW, 8'hD2);
    wreg(`OFS_MAIN_CTRL, 8'h8A);
    repeat (2) @(negedge clk);
    chk("mux", 2'h2, mux);
    chk("bias third", 2'h2, bias);
    period();
    period();
    chk("lf period", 32, n);
    ladder(2'h3, 2'h1);
    wreg(`OFS_LADDER_SW, 8'hD0);
    ladder(2'h1, 2'h1);
    wreg(`OFS_FRAME_PS, 8'h43);
    period();
    period();
    chk("ratio four", 128, n);
    chk("half bias", 1'b1, hbs);
    chk("bias half", 2'h1, bias);
    wreg(`OFS_FRAME_PS, 8'h00);
    slp <= 1'b1;
    period();
    period();
    chk("lf in sleep", 32, n);
    rchk("status", `OFS_STATUS, 8'h80);
    // Stalled source: no frame may come out of it
    @(posedge clk) lf <= 1'b0;
    n = 0;
    repeat (70) @(negedge clk) if (tick === 1'b1) n++;
    chk("lf stopped", 0, n);
    @(posedge clk) lf <= 1'b1;
    wreg(`OFS_MAIN_CTRL, 8'h84);
    period();
    period();
    chk("crystal period", 64, n);
    chk("bias static", 2'h0, bias);
    $display("test oscillators done");
    @(posedge clk) slp <= 1'b0;
    wreg(`OFS_MAIN_CTRL, 8'h80);
    period();
    period();
    chk("sys div period", 8192, n);
    @(posedge clk) slp <= 1'b1;
    repeat (4) @(negedge clk);
    chk("sys div sleep", 1'b0, act);
    chk("ladder off", 2'h0, pwr);
    chk("glass frames", 1'b1, frames != 16'h0000);
    $display("test frame timing done");
    summarize();
  end
endmodule
`default_nettype wire
